// [core/pam_pkg.sv]
// package: register map, masks, bit positions and codes of the port mux
package pam_pkg;
  // register data width inside the block; the bus upper half reads zero
  localparam int unsigned PAM_RW = 16;
  // block byte offsets on the register bus
  localparam logic [7:0] PAM_OFS_PORT0 = 8'h00;
  localparam logic [7:0] PAM_OFS_PORT3 = 8'h20;
  localparam logic [7:0] PAM_OFS_PORT4 = 8'h40;
  localparam logic [7:0] PAM_OFS_EDGE = 8'h60;
  // word index of each register inside a port block
  localparam logic [2:0] PAM_K_LATCH = 3'h0;
  localparam logic [2:0] PAM_K_DIR = 3'h1;
  localparam logic [2:0] PAM_K_MODE = 3'h2;
  localparam logic [2:0] PAM_K_FSEL = 3'h3;
  localparam logic [2:0] PAM_K_FSELX = 3'h4;
  localparam logic [2:0] PAM_K_PULL = 3'h5;
  // word index inside the edge block
  localparam logic [2:0] PAM_K_RISE = 3'h0;
  localparam logic [2:0] PAM_K_FALL = 3'h1;
  // port index codes
  localparam logic [1:0] PAM_PT0 = 2'h0;
  localparam logic [1:0] PAM_PT3 = 2'h1;
  localparam logic [1:0] PAM_PT4 = 2'h2;
  localparam logic [1:0] PAM_PTE = 2'h3;
  // implemented bits per port and per select register
  localparam logic [15:0] PAM_P0_BITS = 16'h007F;
  localparam logic [15:0] PAM_P3_BITS = 16'h033F;
  localparam logic [15:0] PAM_P4_BITS = 16'h0007;
  localparam logic [15:0] PAM_P0_FSEL = 16'h0008;
  localparam logic [15:0] PAM_P3_FSEL = 16'h003C;
  localparam logic [15:0] PAM_P3_FSELX = 16'h0018;
  localparam logic [15:0] PAM_EDGE_BITS = 16'h003F;
  // reset values: every pin an input, port mode, no pull-up
  localparam logic [15:0] PAM_DIR_RST = 16'hFFFF;
  localparam logic [15:0] PAM_CLR_RST = 16'h0000;
  // port 0 pin positions
  localparam int unsigned PAM_B0_HTO0 = 0;
  localparam int unsigned PAM_B0_HTO1 = 1;
  localparam int unsigned PAM_B0_NMI = 2;
  localparam int unsigned PAM_B0_IRQ0 = 3;
  // port 3 pin positions
  localparam int unsigned PAM_B3_TXD = 0;
  localparam int unsigned PAM_B3_RXD = 1;
  localparam int unsigned PAM_B3_CLKTRG = 2;
  localparam int unsigned PAM_B3_TMA = 3;
  localparam int unsigned PAM_B3_TMB = 4;
  localparam int unsigned PAM_B3_TMC = 5;
  localparam int unsigned PAM_B3_SDA = 8;
  localparam int unsigned PAM_B3_SCL = 9;
  // port 4 pin positions
  localparam int unsigned PAM_B4_SIN = 0;
  localparam int unsigned PAM_B4_SOUT = 1;
  localparam int unsigned PAM_B4_SCLK = 2;
  // edge line indices
  localparam int unsigned PAM_EV_NMI = 0;
  localparam int unsigned PAM_EV_IRQ0 = 1;
  localparam int unsigned PAM_EV_IRQ7 = 5;
  localparam int unsigned PAM_NEV = 6;
  // two-bit timer pin function code {ext select, select}
  typedef enum logic [1:0] {
    PAM_FN_CAP_IN = 2'h0,
    PAM_FN_TMR_OUT = 2'h1,
    PAM_FN_T2_IN = 2'h2,
    PAM_FN_T2_OUT = 2'h3
  } pam_fn_t;
  // noise filter: cycles a level must stay stable
  localparam int unsigned PAM_NF_CYCLES = 3;
endpackage

// [core/pam_edge_filter.sv]
// noise elimination and edge detection for the interrupt-capable inputs
`timescale 1ns/1ps
`default_nettype none
module pam_edge_filter #(
  parameter int unsigned WIDTH = 6,
  parameter int unsigned STABLE_CYCLES = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] lvl_in,
  input wire logic [WIDTH-1:0] rise_en,
  input wire logic [WIDTH-1:0] fall_en,
  output logic [WIDTH-1:0] edge_pulse
);
  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYCLES - 1);

  // refuse a filter length the counter cannot serve
  if (STABLE_CYCLES < 1 || WIDTH < 1) begin : g_bad_param
    $error("pam_edge_filter: STABLE_CYCLES and WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] filt_q; // accepted (filtered) level per line

  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    logic [CW-1:0] cnt_q; // cycles the raw level has differed
    // a level is accepted only after it held STABLE_CYCLES cycles
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_q <= '0;
        filt_q[i] <= 1'b0;
        edge_pulse[i] <= 1'b0;
      end else begin
        edge_pulse[i] <= 1'b0;
        if (lvl_in[i] == filt_q[i]) begin
          cnt_q <= '0; // glitch shorter than the window: dropped
        end else if (cnt_q == CNT_LAST) begin
          cnt_q <= '0;
          filt_q[i] <= lvl_in[i];
          // edge sense chosen by the per-line enables
          edge_pulse[i] <= lvl_in[i] ? rise_en[i] : fall_en[i];
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [core/pam_port_mux.sv]
// port alternate-function mux for ports 0, 3 and 4 with AHB-Lite registers
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - output buffer off forces pin drivers off
// - mode bit set selects peripheral, ignores latch
// - port0 bit3 is irq0 only with select 0
// - port3 bit3 two-bit select picks timer function
// - port3 bit4 same two-bit timer decode
// - port3 bit5 select: capture in or timer out
// - port3 bit2: uart clock+adc trigger, or timer
// - port3 bits 8,9 carry i2c data, clock
// - port4 bits 0-2 carry clocked serial lines
// - interrupt inputs filtered then edge detected
module pam_port_mux import pam_pkg::*; #(
  parameter int unsigned NF_CYCLES = PAM_NF_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // low-power / bus-hold driver kill
  input wire logic obuf_off,
  // package pins
  input wire logic [15:0] p0_pin_in,
  output logic [15:0] p0_pin_out,
  output logic [15:0] p0_pin_oe,
  output logic [15:0] p0_pullup_en,
  input wire logic [15:0] p3_pin_in,
  output logic [15:0] p3_pin_out,
  output logic [15:0] p3_pin_oe,
  output logic [15:0] p3_pullup_en,
  input wire logic [15:0] p4_pin_in,
  output logic [15:0] p4_pin_out,
  output logic [15:0] p4_pin_oe,
  output logic [15:0] p4_pullup_en,
  // peripheral outputs routed to pins
  input wire logic hs_timer_out0,
  input wire logic hs_timer_out1,
  input wire logic uart_tx_out,
  input wire logic timer_out_a,
  input wire logic timer_out_b,
  input wire logic second_timer_out_a,
  input wire logic second_timer_out_b,
  input wire logic i2c_sda_drive_low,
  input wire logic i2c_scl_drive_low,
  input wire logic csi_serial_out,
  input wire logic csi_serial_clock_out,
  input wire logic csi_serial_clock_oe,
  // pin inputs routed to peripherals
  output logic uart_rx_in,
  output logic uart_ext_clock_in,
  output logic adc_ext_trigger_in,
  output logic timer_capture_in_a,
  output logic timer_capture_in_b,
  output logic timer_capture_in_c,
  output logic second_timer_in_a,
  output logic second_timer_in_b,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic csi_serial_in,
  output logic csi_serial_clock_in,
  // filtered edge pulses: nmi, irq0..irq3, irq7
  output logic [PAM_NEV-1:0] irq_edge
);

  // ---------------- decode helpers ----------------

  // implemented pins of a port
  function automatic logic [15:0] pam_bits(input logic [1:0] pt);
    logic [15:0] m;
    m = PAM_CLR_RST;
    case (pt)
      PAM_PT0: m = PAM_P0_BITS;
      PAM_PT3: m = PAM_P3_BITS;
      PAM_PT4: m = PAM_P4_BITS;
      default: m = PAM_EDGE_BITS;
    endcase
    return m;
  endfunction

  // writable/readable bits of one register
  function automatic logic [15:0] pam_mask(input logic [1:0] pt, input logic [2:0] k);
    logic [15:0] m;
    m = pam_bits(pt);
    if (pt != PAM_PTE && k == PAM_K_FSEL) begin
      m = (pt == PAM_PT0) ? PAM_P0_FSEL : (pt == PAM_PT3) ? PAM_P3_FSEL : PAM_CLR_RST;
    end else if (pt != PAM_PTE && k == PAM_K_FSELX) begin
      m = (pt == PAM_PT3) ? PAM_P3_FSELX : PAM_CLR_RST;
    end
    return m;
  endfunction

  // address to {hit, port, kind}
  function automatic logic [5:0] pam_decode(input logic [7:0] a);
    logic hit;
    logic [1:0] pt;
    logic [2:0] k;
    hit = (a[1:0] == 2'h0);
    k = a[4:2];
    pt = PAM_PTE;
    case ({a[7:5], 5'h00})
      PAM_OFS_PORT0: pt = PAM_PT0;
      PAM_OFS_PORT3: pt = PAM_PT3;
      PAM_OFS_PORT4: pt = PAM_PT4;
      PAM_OFS_EDGE: pt = PAM_PTE;
      default: hit = 1'b0;
    endcase
    // kinds past the last register of a block are unmapped
    if (pt == PAM_PTE && k > PAM_K_FALL) begin
      hit = 1'b0;
    end
    if (pt != PAM_PTE && k > PAM_K_PULL) begin
      hit = 1'b0;
    end
    return {hit, pt, k};
  endfunction

  // ---------------- register bus ----------------

  logic addr_take; // address phase accepted this edge
  logic [5:0] dec_a; // decode of the address phase
  logic wr_pend_q; // write data phase in progress
  logic [5:0] wsel_q; // decode held for the data phase
  logic [31:0] hrdata_q; // read data, loaded at the address phase
  logic [15:0] rd_val; // combinational read value
  logic wr_en; // register write strobe
  logic [1:0] w_pt;
  logic [2:0] w_k;
  logic [15:0] w_m;

  assign addr_take = hsel & htrans[1] & hready;
  assign dec_a = pam_decode(haddr[7:0]);
  // a read right behind a write waits one cycle so it sees the new value
  assign hreadyout = ~(wr_pend_q & hsel & htrans[1] & ~hwrite);
  assign hresp = 1'b0; // always OKAY, unmapped reads zero
  assign hrdata = hrdata_q;
  assign wr_en = wr_pend_q & wsel_q[5];
  assign w_pt = wsel_q[4:3];
  assign w_k = wsel_q[2:0];
  assign w_m = pam_mask(w_pt, w_k);

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wsel_q <= '0;
    end else begin
      wr_pend_q <= addr_take & hwrite;
      wsel_q <= addr_take ? dec_a : wsel_q;
    end
  end

  // read data is ready during the data phase, no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (addr_take && !hwrite) begin
      hrdata_q <= {16'h0000, rd_val};
    end
  end

  // ---------------- configuration registers ----------------

  logic [15:0] latch_q [3]; // output latches
  logic [15:0] dir_q [3]; // direction, 1 = input
  logic [15:0] mode_q [3]; // mode control, 1 = alternate
  logic [15:0] fsel_q [3]; // function select
  logic [15:0] fselx_q [3]; // extended function select
  logic [15:0] pull_q [3]; // pull-up enable
  logic [15:0] rise_q; // rising edge enables
  logic [15:0] fall_q; // falling edge enables

  // port registers: latch and direction merge the masked written bits, the rest take the masked word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        latch_q[p] <= PAM_CLR_RST;
        dir_q[p] <= PAM_DIR_RST;
        mode_q[p] <= PAM_CLR_RST;
        fsel_q[p] <= PAM_CLR_RST;
        fselx_q[p] <= PAM_CLR_RST;
        pull_q[p] <= PAM_CLR_RST;
      end
    end else if (wr_en && w_pt != PAM_PTE) begin
      case (w_k)
        PAM_K_LATCH: latch_q[w_pt] <= (latch_q[w_pt] & ~w_m) | (hwdata[15:0] & w_m);
        PAM_K_DIR: dir_q[w_pt] <= (dir_q[w_pt] & ~w_m) | (hwdata[15:0] & w_m);
        PAM_K_MODE: mode_q[w_pt] <= hwdata[15:0] & w_m;
        PAM_K_FSEL: fsel_q[w_pt] <= hwdata[15:0] & w_m;
        PAM_K_FSELX: fselx_q[w_pt] <= hwdata[15:0] & w_m;
        PAM_K_PULL: pull_q[w_pt] <= hwdata[15:0] & w_m;
        default: ;
      endcase
    end
  end

  // edge enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_q <= PAM_CLR_RST;
      fall_q <= PAM_CLR_RST;
    end else if (wr_en && w_pt == PAM_PTE) begin
      if (w_k == PAM_K_RISE) begin
        rise_q <= hwdata[15:0] & w_m;
      end else begin
        fall_q <= hwdata[15:0] & w_m;
      end
    end
  end

  // ---------------- pin input synchronisers ----------------

  logic [15:0] pin_raw [3];
  logic [15:0] sync1_q [3]; // first stage, read only by sync2
  logic [15:0] sync2_q [3]; // settled pin level

  assign pin_raw[0] = p0_pin_in;
  assign pin_raw[1] = p3_pin_in;
  assign pin_raw[2] = p4_pin_in;

  // two flops before any logic looks at a pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        sync1_q[p] <= PAM_CLR_RST;
        sync2_q[p] <= PAM_CLR_RST;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        sync1_q[p] <= pin_raw[p];
        sync2_q[p] <= sync1_q[p];
      end
    end
  end

  // ---------------- read mux ----------------

  logic [1:0] r_pt;
  logic [2:0] r_k;
  assign r_pt = dec_a[4:3];
  assign r_k = dec_a[2:0];

  // port read shows the pin unless the pin is a port-mode output
  always_comb begin
    rd_val = PAM_CLR_RST;
    if (!dec_a[5]) begin
      rd_val = PAM_CLR_RST; // unmapped reads zero
    end else if (r_pt == PAM_PTE) begin
      rd_val = (r_k == PAM_K_RISE) ? rise_q : fall_q;
    end else begin
      case (r_k)
        PAM_K_LATCH: rd_val = ((dir_q[r_pt] | mode_q[r_pt]) & sync2_q[r_pt])
                            | (~dir_q[r_pt] & ~mode_q[r_pt] & latch_q[r_pt]);
        PAM_K_DIR: rd_val = dir_q[r_pt];
        PAM_K_MODE: rd_val = mode_q[r_pt];
        PAM_K_FSEL: rd_val = fsel_q[r_pt];
        PAM_K_FSELX: rd_val = fselx_q[r_pt];
        PAM_K_PULL: rd_val = pull_q[r_pt];
        default: rd_val = PAM_CLR_RST;
      endcase
      rd_val = rd_val & pam_mask(r_pt, r_k);
    end
  end

  // ---------------- output pin mux ----------------

  logic [15:0] out_d [3];
  logic [15:0] oe_d [3];
  pam_fn_t fn_a; // port 3 bit 3 function
  pam_fn_t fn_b; // port 3 bit 4 function

  assign fn_a = pam_fn_t'({fselx_q[1][PAM_B3_TMA], fsel_q[1][PAM_B3_TMA]});
  assign fn_b = pam_fn_t'({fselx_q[1][PAM_B3_TMB], fsel_q[1][PAM_B3_TMB]});

  // port mode drives latch per direction; mode bit hands the pin over
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      out_d[p] = latch_q[p];
      oe_d[p] = ~dir_q[p] & ~mode_q[p] & pam_bits(2'(p));
    end
    // port 0: high-speed timer outputs, other pins are inputs
    if (mode_q[0][PAM_B0_HTO0]) begin
      out_d[0][PAM_B0_HTO0] = hs_timer_out0;
      oe_d[0][PAM_B0_HTO0] = 1'b1;
    end
    if (mode_q[0][PAM_B0_HTO1]) begin
      out_d[0][PAM_B0_HTO1] = hs_timer_out1;
      oe_d[0][PAM_B0_HTO1] = 1'b1;
    end
    // port 3 bit 0: uart transmit
    if (mode_q[1][PAM_B3_TXD]) begin
      out_d[1][PAM_B3_TXD] = uart_tx_out;
      oe_d[1][PAM_B3_TXD] = 1'b1;
    end
    // port 3 bit 2: drives only with select 1
    if (mode_q[1][PAM_B3_CLKTRG] && fsel_q[1][PAM_B3_CLKTRG]) begin
      out_d[1][PAM_B3_CLKTRG] = timer_out_b;
      oe_d[1][PAM_B3_CLKTRG] = 1'b1;
    end
    // port 3 bit 3: odd codes are outputs
    if (mode_q[1][PAM_B3_TMA]) begin
      out_d[1][PAM_B3_TMA] = (fn_a == PAM_FN_TMR_OUT) ? timer_out_a : second_timer_out_a;
      oe_d[1][PAM_B3_TMA] = (fn_a == PAM_FN_TMR_OUT) || (fn_a == PAM_FN_T2_OUT);
    end
    // port 3 bit 4: same decode; code 1 drives timer_out_a, code 3 second_timer_out_b
    if (mode_q[1][PAM_B3_TMB]) begin
      out_d[1][PAM_B3_TMB] = (fn_b == PAM_FN_TMR_OUT) ? timer_out_a : second_timer_out_b;
      oe_d[1][PAM_B3_TMB] = (fn_b == PAM_FN_TMR_OUT) || (fn_b == PAM_FN_T2_OUT);
    end
    // port 3 bit 5: timer output with select 1
    if (mode_q[1][PAM_B3_TMC]) begin
      out_d[1][PAM_B3_TMC] = timer_out_b;
      oe_d[1][PAM_B3_TMC] = fsel_q[1][PAM_B3_TMC];
    end
    // i2c lines are open drain: only ever pull low
    if (mode_q[1][PAM_B3_SDA]) begin
      out_d[1][PAM_B3_SDA] = 1'b0;
      oe_d[1][PAM_B3_SDA] = i2c_sda_drive_low;
    end
    if (mode_q[1][PAM_B3_SCL]) begin
      out_d[1][PAM_B3_SCL] = 1'b0;
      oe_d[1][PAM_B3_SCL] = i2c_scl_drive_low;
    end
    // port 4: serial out and two-way serial clock
    if (mode_q[2][PAM_B4_SOUT]) begin
      out_d[2][PAM_B4_SOUT] = csi_serial_out;
      oe_d[2][PAM_B4_SOUT] = 1'b1;
    end
    if (mode_q[2][PAM_B4_SCLK]) begin
      out_d[2][PAM_B4_SCLK] = csi_serial_clock_out;
      oe_d[2][PAM_B4_SCLK] = csi_serial_clock_oe;
    end
    // driver kill wins over every function, inputs keep working
    if (obuf_off) begin
      for (int p = 0; p < 3; p++) begin
        oe_d[p] = PAM_CLR_RST;
      end
    end
  end

  logic [15:0] pin_out_q [3];
  logic [15:0] pin_oe_q [3];
  logic [15:0] pull_en_q [3];

  // pins driven from flops; pull-up only where nothing drives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        pin_out_q[p] <= PAM_CLR_RST;
        pin_oe_q[p] <= PAM_CLR_RST;
        pull_en_q[p] <= PAM_CLR_RST;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        pin_out_q[p] <= out_d[p] & pam_bits(2'(p));
        pin_oe_q[p] <= oe_d[p];
        pull_en_q[p] <= pull_q[p] & ~oe_d[p];
      end
    end
  end

  assign p0_pin_out = pin_out_q[0];
  assign p0_pin_oe = pin_oe_q[0];
  assign p0_pullup_en = pull_en_q[0];
  assign p3_pin_out = pin_out_q[1];
  assign p3_pin_oe = pin_oe_q[1];
  assign p3_pullup_en = pull_en_q[1];
  assign p4_pin_out = pin_out_q[2];
  assign p4_pin_oe = pin_oe_q[2];
  assign p4_pullup_en = pull_en_q[2];

  // ---------------- pin inputs to peripherals ----------------

  logic [15:0] m3;
  logic [15:0] s3;
  assign m3 = mode_q[1];
  assign s3 = sync2_q[1];

  // unselected inputs rest at their idle level, so peripherals see no edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart_rx_in <= 1'b1;
      uart_ext_clock_in <= 1'b0;
      adc_ext_trigger_in <= 1'b0;
      timer_capture_in_a <= 1'b0;
      timer_capture_in_b <= 1'b0;
      timer_capture_in_c <= 1'b0;
      second_timer_in_a <= 1'b0;
      second_timer_in_b <= 1'b0;
      i2c_sda_in <= 1'b1;
      i2c_scl_in <= 1'b1;
      csi_serial_in <= 1'b0;
      csi_serial_clock_in <= 1'b1;
    end else begin
      // shared with irq7; software keeps the unused one quiet
      uart_rx_in <= m3[PAM_B3_RXD] ? s3[PAM_B3_RXD] : 1'b1;
      // one pin feeds both; software disables the unwanted user
      uart_ext_clock_in <= m3[PAM_B3_CLKTRG] & ~fsel_q[1][PAM_B3_CLKTRG] & s3[PAM_B3_CLKTRG];
      adc_ext_trigger_in <= m3[PAM_B3_CLKTRG] & ~fsel_q[1][PAM_B3_CLKTRG] & s3[PAM_B3_CLKTRG];
      timer_capture_in_a <= m3[PAM_B3_TMA] & (fn_a == PAM_FN_CAP_IN) & s3[PAM_B3_TMA];
      second_timer_in_a <= m3[PAM_B3_TMA] & (fn_a == PAM_FN_T2_IN) & s3[PAM_B3_TMA];
      timer_capture_in_b <= m3[PAM_B3_TMB] & (fn_b == PAM_FN_CAP_IN) & s3[PAM_B3_TMB];
      second_timer_in_b <= m3[PAM_B3_TMB] & (fn_b == PAM_FN_T2_IN) & s3[PAM_B3_TMB];
      timer_capture_in_c <= m3[PAM_B3_TMC] & ~fsel_q[1][PAM_B3_TMC] & s3[PAM_B3_TMC];
      i2c_sda_in <= m3[PAM_B3_SDA] ? s3[PAM_B3_SDA] : 1'b1;
      i2c_scl_in <= m3[PAM_B3_SCL] ? s3[PAM_B3_SCL] : 1'b1;
      csi_serial_in <= mode_q[2][PAM_B4_SIN] & sync2_q[2][PAM_B4_SIN];
      csi_serial_clock_in <= mode_q[2][PAM_B4_SCLK] ? sync2_q[2][PAM_B4_SCLK] : 1'b1;
    end
  end

  // ---------------- interrupt inputs ----------------

  logic [PAM_NEV-1:0] ev_lvl; // gated level per interrupt line

  // port 0 bits 2..6 map onto lines 0..4, irq7 from port 3 bit 1
  always_comb begin
    ev_lvl = '0;
    for (int i = 0; i < PAM_EV_IRQ7; i++) begin
      ev_lvl[i] = mode_q[0][PAM_B0_NMI + i] & sync2_q[0][PAM_B0_NMI + i];
    end
    // irq0 only while its select bit is 0
    ev_lvl[PAM_EV_IRQ0] = ev_lvl[PAM_EV_IRQ0] & ~fsel_q[0][PAM_B0_IRQ0];
    ev_lvl[PAM_EV_IRQ7] = m3[PAM_B3_RXD] & s3[PAM_B3_RXD];
  end

  // filter then edge detect, enables per line
  pam_edge_filter #(
    .WIDTH(PAM_NEV),
    .STABLE_CYCLES(NF_CYCLES)
  ) u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .lvl_in(ev_lvl),
    .rise_en(rise_q[PAM_NEV-1:0]),
    .fall_en(fall_q[PAM_NEV-1:0]),
    .edge_pulse(irq_edge)
  );

endmodule
`default_nettype wire

// [dv/pam_pin_model.sv]
// pad model
`timescale 1ns/1ps
`default_nettype none
module pam_pin_model (
  input wire logic [15:0] drv,
  input wire logic [15:0] oe,
  input wire logic [15:0] ext,
  output logic [15:0] pin
);
  // driven pins show the mux, others the outside
  assign pin = (oe & drv) | (~oe & ext);
endmodule
`default_nettype wire

// [dv/pam_port_mux_monitor.sv]
// pin-mux checker
`timescale 1ns/1ps
`default_nettype none
module pam_port_mux_monitor import pam_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic obuf_off,
  input wire logic [15:0] p0_pin_oe,
  input wire logic [15:0] p3_pin_oe,
  input wire logic [15:0] p4_pin_oe,
  input wire logic [15:0] p3_pin_in,
  input wire logic [15:0] p4_pin_in,
  input wire logic uart_ext_clock_in,
  input wire logic adc_ext_trigger_in,
  input wire logic timer_capture_in_a,
  input wire logic timer_capture_in_c,
  input wire logic second_timer_in_a,
  input wire logic csi_serial_in,
  input wire logic [PAM_NEV-1:0] irq_edge
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_obuf_oe_off: assert property (obuf_off |=> !(p0_pin_oe | p3_pin_oe | p4_pin_oe))
    else $error("oe with buffer off");
  a_wait_once: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  a_hi_half: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper half set");
  a_clk_trg_pair: assert property (uart_ext_clock_in == adc_ext_trigger_in)
    else $error("clock/trigger differ");
  a_tmr_excl: assert property (!(timer_capture_in_a && second_timer_in_a))
    else $error("two timer inputs");
  a_cap_c_lag: assert property (timer_capture_in_c |-> $past(p3_pin_in[5], 3))
    else $error("capture not pin");
  a_csi_lag: assert property (csi_serial_in |-> $past(p4_pin_in[0], 3))
    else $error("serial not pin");
  a_edge_single: assert property ((irq_edge & $past(irq_edge)) == 6'h00)
    else $error("edge pulse too wide");
endmodule
`default_nettype wire

// [dv/test_port_alternate_function_mux.sv]
// bench of the port mux
`timescale 1ns/1ps
`default_nettype none
module test_port_alternate_function_mux import pam_pkg::*; ;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, obuf_off = 1'b0, hreadyout;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [15:0] ext0 = 16'h0, ext3 = 16'h0, ext4 = 16'h0, p0i, p3i, p4i, p0o, p3o, p4o, p0e, p3e, p4e;
  logic [11:0] per = 12'h0; // peripherals
  logic [5:0] irq;
  logic tca, tcb, tcc, sta, stb, uck, sdi, csi;
  int err_total = 0, tests_run = 0;
  logic [15:0] mdl [4][6]; // register model
  initial forever #10 hclk = ~hclk;
  pam_port_mux i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp(), .obuf_off, .p0_pin_in(p0i), .p0_pin_out(p0o),
    .p0_pin_oe(p0e), .p0_pullup_en(), .p3_pin_in(p3i), .p3_pin_out(p3o), .p3_pin_oe(p3e),
    .p3_pullup_en(), .p4_pin_in(p4i), .p4_pin_out(p4o), .p4_pin_oe(p4e), .p4_pullup_en(),
    .hs_timer_out0(per[0]), .hs_timer_out1(per[1]), .uart_tx_out(per[2]), .timer_out_a(per[3]),
    .timer_out_b(per[4]), .second_timer_out_a(per[5]), .second_timer_out_b(per[6]),
    .i2c_sda_drive_low(per[7]), .i2c_scl_drive_low(per[8]), .csi_serial_out(per[9]),
    .csi_serial_clock_out(per[10]), .csi_serial_clock_oe(per[11]), .uart_rx_in(),
    .uart_ext_clock_in(uck), .adc_ext_trigger_in(), .timer_capture_in_a(tca), .timer_capture_in_b(tcb),
    .timer_capture_in_c(tcc), .second_timer_in_a(sta), .second_timer_in_b(stb), .i2c_sda_in(sdi),
    .i2c_scl_in(), .csi_serial_in(csi), .csi_serial_clock_in(), .irq_edge(irq));
  pam_pin_model i_pm0 (.drv(p0o), .oe(p0e), .ext(ext0), .pin(p0i));
  pam_pin_model i_pm3 (.drv(p3o), .oe(p3e), .ext(ext3), .pin(p3i));
  pam_pin_model i_pm4 (.drv(p4o), .oe(p4e), .ext(ext4), .pin(p4i));
  // masks
  function automatic logic [15:0] msk(input int p, input int k);
    if (p == 3) return PAM_EDGE_BITS;
    if (k == 3) return (p == 0) ? PAM_P0_FSEL : (p == 1) ? PAM_P3_FSEL : 16'h0000;
    if (k == 4) return (p == 1) ? PAM_P3_FSELX : 16'h0000;
    return (p == 0) ? PAM_P0_BITS : (p == 1) ? PAM_P3_BITS : PAM_P4_BITS;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // hready edge
  task automatic wt();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  // single transfers; a write is read back
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    for (int i = w ? 0 : 1; i < 2; i++) begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= i == 0;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
    end
    r = hrdata;
  endtask
  task automatic cfg(input int p, input int k, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, 8'(p * 32 + k * 4), {16'h0000, d}, r);
    mdl[p][k] = d & msk(p, k);
    if (k != 0 || p == 3) chk("readback", {16'h0000, mdl[p][k]}, r);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic b1;
    int n;
    void'($urandom(3));
    for (int p = 0; p < 4; p++) for (int k = 0; k < 6; k++) mdl[p][k] = (k == 1 && p < 3) ? msk(p, 1) : 16'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int p = 0; p < 4; p++) for (int k = 0; k < 6; k++) if ((p < 3 && k > 0) || (p == 3 && k < 2)) begin
      bus(1'b0, 8'(p * 32 + k * 4), 32'h0, r);
      chk("reset value", {16'h0000, mdl[p][k]}, r);
    end
    bus(1'b1, 8'h7C, $urandom, r);
    chk("unmapped", 32'h0, r);
    repeat (12) cfg($urandom_range(2), $urandom_range(5, 1), 16'($urandom));
    $display("registers done");
    // port mode
    ext0 <= 16'($urandom);
    cfg(0, 2, 16'h0000);
    cfg(0, 1, 16'h0070);
    cfg(0, 0, 16'($urandom));
    per <= {10'($urandom), ~mdl[0][0][1:0]};
    repeat (4) @(posedge hclk);
    bus(1'b0, PAM_OFS_PORT0, 32'h0, r);
    chk("port read", {16'h0, (mdl[0][1] & ext0 | ~mdl[0][1] & mdl[0][0]) & PAM_P0_BITS}, r);
    chk("port drive", {~mdl[0][1] & PAM_P0_BITS, mdl[0][0] & ~mdl[0][1] & PAM_P0_BITS}, {p0e, p0o & p0e});
    cfg(0, 2, 16'h0003);
    chk("timer pins", {30'h0, per[1:0]}, {30'h0, p0o[1:0]});
    obuf_off <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("buffer off", 32'h0, {16'h0, p0e | p3e | p4e});
    obuf_off <= 1'b0;
    $display("port mode done");
    // timer codes
    for (int c = 0; c < 4; c++) begin
      b1 = c[1];
      per <= 12'($urandom);
      ext3 <= 16'($urandom);
      cfg(1, 2, 16'h003C);
      cfg(1, 3, c[0] ? 16'h003C : 16'h0000);
      cfg(1, 4, b1 ? 16'h0018 : 16'h0000);
      repeat (4) @(posedge hclk);
      if (c[0]) chk("timer out", {per[4], b1 ? per[6] : per[3], b1 ? per[5] : per[3], per[4]}, p3o[5:2]);
      else chk("timer in", {ext3[5], ~b1 & ext3[3], ~b1 & ext3[4], b1 & ext3[3], b1 & ext3[4], ext3[2]},
        {tcc, tca, tcb, sta, stb, uck});
    end
    $display("timer select done");
    per <= 12'($urandom);
    ext3 <= 16'($urandom);
    ext4 <= 16'($urandom);
    cfg(1, 2, 16'h0300);
    cfg(2, 2, 16'h0007);
    repeat (4) @(posedge hclk);
    chk("i2c", {per[8:7], ~per[7] & ext3[8]}, {p3e[9:8], sdi});
    chk("serial", {per[11], per[9], ext4[0]}, {p4e[2], p4o[1], csi});
    $display("serial done");
    // p0.3 edges
    ext0 <= 16'h0000;
    cfg(0, 2, 16'h0008);
    cfg(0, 3, 16'h0000);
    cfg(3, 1, 16'h0000);
    cfg(3, 0, 16'h0002);
    for (int c = 0; c < 4; c++) begin
      if (c == 3) cfg(3, 1, 16'h0002);
      n = 0;
      ext0[3] <= ~ext0[3];
      repeat (20) begin
        @(posedge hclk);
        n += (irq[1] === 1'b1);
      end
      chk("edge count", 32'(c != 1), 32'(n));
    end
    $display("edges done");
    complete_run();
  end
endmodule
bind pam_port_mux pam_port_mux_monitor i_mon (.hclk, .hresetn, .hreadyout, .hrdata,
  .obuf_off, .p0_pin_oe, .p3_pin_oe, .p4_pin_oe, .p3_pin_in, .p4_pin_in, .uart_ext_clock_in, .adc_ext_trigger_in,
  .timer_capture_in_a, .timer_capture_in_c, .second_timer_in_a, .csi_serial_in, .irq_edge);
`default_nettype wire
